// File: switch_port_mac.sv
// ten-port mac frame control with uplink pre tagging at 100 Mbps and post tagging
// assumes frame events from the line side and a free uplink clock
`timescale 1ns/10ps
module switch_port_mac (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_uplink_clk,
  input wire logic i_cfg_wr,
  input wire logic [15:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_ram_size_config,
  output logic o_local_switch_disable,
  input wire logic [switch_mac_pkg::NPORTS*8-1:0] i_port_ctrl,
  input wire logic [switch_mac_pkg::NPORTS-1:0] i_full_duplex,
  input wire logic [switch_mac_pkg::NPORTS-1:0] i_speed100,
  input wire logic [switch_mac_pkg::NPORTS-1:0] i_cut_through,
  input wire logic i_long_stats,
  input wire logic [switch_mac_pkg::NPORTS-1:0] i_rx_done,
  input wire logic [switch_mac_pkg::NPORTS*11-1:0] i_rx_len,
  input wire logic [switch_mac_pkg::NPORTS-1:0] i_rx_crc_err,
  input wire logic [switch_mac_pkg::NPORTS-1:0] i_rx_align_err,
  input wire logic [switch_mac_pkg::NPORTS-1:0] i_dest_busy,
  output logic [switch_mac_pkg::NPORTS-1:0] o_rx_store,
  output logic [switch_mac_pkg::NPORTS-1:0] o_rx_drop,
  output logic [switch_mac_pkg::NPORTS-1:0] o_rx_truncate,
  output logic [switch_mac_pkg::NPORTS-1:0] o_stat_long_bin,
  output logic [switch_mac_pkg::NPORTS-1:0] o_stat_jabber,
  output logic [switch_mac_pkg::NPORTS-1:0] o_stat_crc,
  output logic [switch_mac_pkg::NPORTS-1:0] o_stat_align,
  output logic [switch_mac_pkg::NPORTS-1:0] o_buf_release,
  input wire logic [switch_mac_pkg::NPORTS-1:0] i_tx_req,
  input wire logic [switch_mac_pkg::NPORTS*11-1:0] i_tx_len,
  input wire logic [switch_mac_pkg::NPORTS-1:0] i_port_carrier_sense,
  input wire logic [switch_mac_pkg::NPORTS-1:0] i_port_collision,
  output logic [switch_mac_pkg::NPORTS-1:0] o_port_tx_enable,
  output logic [switch_mac_pkg::NPORTS-1:0] o_tx_release,
  output logic [switch_mac_pkg::NPORTS-1:0] o_tx_retry,
  output logic [switch_mac_pkg::NPORTS-1:0] o_tx_late,
  output logic [switch_mac_pkg::NPORTS-1:0] o_tx_excess,
  input wire logic [3:0] i_uplink_src_port,
  input wire logic [3:0] i_uplink_tx_data,
  output logic o_uplink_tx_enable,
  output logic [3:0] o_uplink_tx_nibble,
  input wire logic i_uplink_rx_valid,
  input wire logic [3:0] i_uplink_rx_nibble,
  output logic [3:0] o_fwd_pointer_tag,
  output logic [9:0] o_uplink_dest,
  output logic o_uplink_frame,
  output logic o_uplink_unicast,
  output logic o_uplink_multicast,
  output logic o_uplink_discard
);
  localparam int NP = switch_mac_pkg::NPORTS;
  localparam int LW = switch_mac_pkg::LEN_W;
  localparam int CW = switch_mac_pkg::CNT_W;

  // ==========================================================
  // core state: config register and uplink rx results
  typedef struct packed {
    logic [7:0] ram_size_config;
    logic [3:0] src;
    logic tgl1;
    logic tgl2;
    logic tgl3;
    logic [3:0] tag;
    logic [9:0] dest;
    logic frame;
    logic uni;
    logic multi;
    logic disc;
  } core_s;
  core_s core_q, core_d;
  localparam core_s CORE_RST = '{
    ram_size_config: switch_mac_pkg::RAM_SIZE_CONFIG_RST, default: '0};

  // ==========================================================
  // link state on the uplink clock
  typedef struct packed {
    logic rst1;
    logic rst2;
    logic tx1;
    logic tx2;
    logic tx3;
    logic on1;
    logic on2;
    logic sp1;
    logic sp2;
    logic txen;
    logic [3:0] txd;
    logic [3:0] pre_nib;
    logic pre_val;
    logic [1:0] cnt;
    logic [3:0] tag;
    logic [8:0] pd;
    logic [12:0] word;
    logic tgl;
  } link_s;
  link_s link_q, link_d;

  logic posttag_on;
  logic [NP-1:0] txen_q;
  logic [9:0] mask;

  assign posttag_on = core_q.ram_size_config[switch_mac_pkg::POSTTAG_ENABLE_BIT];

  // ==========================================================
  // core process
  always_comb begin
    core_d = core_q;
    core_d.frame = 1'b0;
    core_d.uni = 1'b0;
    core_d.multi = 1'b0;
    core_d.disc = 1'b0;
    mask = {link_q.word[8:0], 1'b0};
    if (i_cfg_wr && i_cfg_addr == switch_mac_pkg::RAM_SIZE_CONFIG_ADDR) begin
      core_d.ram_size_config = i_cfg_wdata;
    end
    if (!txen_q[0]) begin
      core_d.src = i_uplink_src_port;
    end
    core_d.tgl1 = link_q.tgl;
    core_d.tgl2 = core_q.tgl1;
    core_d.tgl3 = core_q.tgl2;
    if (core_q.tgl2 != core_q.tgl3) begin
      core_d.frame = 1'b1;
      core_d.tag = link_q.word[12:9];
      if (posttag_on) begin
        core_d.dest = mask;
        core_d.uni = $onehot(mask);
        core_d.multi = $countones(mask) > 1;
        core_d.disc = mask == 10'h000;
      end else begin
        core_d.dest = 10'h000;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      core_q <= CORE_RST;
    end else begin
      core_q <= core_d;
    end
  end

  assign o_ram_size_config = core_q.ram_size_config;
  assign o_local_switch_disable = posttag_on;
  assign o_fwd_pointer_tag = core_q.tag;
  assign o_uplink_dest = core_q.dest;
  assign o_uplink_frame = core_q.frame;
  assign o_uplink_unicast = core_q.uni;
  assign o_uplink_multicast = core_q.multi;
  assign o_uplink_discard = core_q.disc;

  unicast_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    core_q.tgl2 != core_q.tgl3 && posttag_on && $onehot(mask)
    |=> o_uplink_unicast && !o_uplink_discard && o_uplink_dest == $past(mask))
    else $error("single posttag bit not unicast");

  // ==========================================================
  // link process: pretag out, pretag and posttag in
  always_comb begin
    link_d = link_q;
    link_d.rst1 = 1'b1;
    link_d.rst2 = link_q.rst1;
    link_d.tx1 = txen_q[0];
    link_d.tx2 = link_q.tx1;
    link_d.tx3 = link_q.tx2;
    link_d.on1 = posttag_on;
    link_d.on2 = link_q.on1;
    link_d.sp1 = i_speed100[0];
    link_d.sp2 = link_q.sp1;
    link_d.txen = 1'b0;
    link_d.txd = i_uplink_tx_data;
    if (link_q.tx2 && !link_q.tx3 && link_q.sp2) begin
      link_d.txd = core_q.src;
    end else if (link_q.tx2) begin
      link_d.txen = 1'b1;
    end
    link_d.pre_nib = i_uplink_rx_nibble;
    link_d.pre_val = i_uplink_rx_valid;
    if (i_uplink_rx_valid && !link_q.pre_val) begin
      link_d.tag = link_q.sp2 ? link_q.pre_nib : 4'h0;
      link_d.pd = {5'h00, i_uplink_rx_nibble};
      link_d.cnt = 2'd1;
    end else if (i_uplink_rx_valid && link_q.on2 &&
                 link_q.cnt != 2'd3) begin
      if (link_q.cnt == 2'd1) begin
        link_d.pd[7:4] = i_uplink_rx_nibble;
      end else begin
        link_d.pd[8] = i_uplink_rx_nibble[0];
      end
      link_d.cnt = link_q.cnt + 2'd1;
    end
    if (!i_uplink_rx_valid && link_q.pre_val) begin
      link_d.word = {link_q.tag, link_q.on2 ? link_q.pd : 9'h000};
      link_d.tgl = ~link_q.tgl;
    end
    if (!link_q.rst2) begin
      link_d = '0;
      link_d.rst1 = 1'b1;
      link_d.rst2 = link_q.rst1;
    end
  end

  always_ff @(posedge i_uplink_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  assign o_uplink_tx_enable = link_q.txen;
  assign o_uplink_tx_nibble = link_q.txd;

  pretag_a: assert property (@(posedge i_uplink_clk) disable iff (i_sys_rst)
    link_q.tx2 && !link_q.tx3 && link_q.sp2 && link_q.rst2
    |=> !o_uplink_tx_enable && o_uplink_tx_nibble == $past(core_q.src)
        ##1 o_uplink_tx_enable)
    else $error("uplink source nibble not ahead of tx enable");

  // ==========================================================
  // per-port receive filter and transmit engine
  for (genvar p = 0; p < NP; p++) begin : g_port
    typedef struct packed {
      logic store;
      logic drop;
      logic trunc;
      logic bin;
      logic jab;
      logic crc;
      logic align;
      logic rel;
    } rx_s;
    typedef struct packed {
      switch_mac_pkg::tx_state_e st;
      logic [CW-1:0] cnt;
      logic [LW-1:0] bytes;
      logic [4:0] tries;
      logic [CW-1:0] pace;
      logic coll;
      logic [9:0] lfsr;
      logic crs1;
      logic crs2;
      logic col1;
      logic col2;
      logic txen;
      logic done;
      logic retry;
      logic late;
      logic excess;
    } tx_s;
    localparam tx_s TX_RST = '{st: switch_mac_pkg::TX_IDLE,
      lfsr: 10'(p + 1), default: '0};
    rx_s rx_q, rx_d;
    tx_s tx_q, tx_d;
    logic [LW-1:0] rlen, tlen, bin_hi;
    logic cut, err, over, fd, crs, col, pace_en;
    logic [CW-1:0] byte_cyc, gap_cyc, pace_cyc;
    logic [9:0] bo_mask;

    assign rlen = i_rx_len[p*LW +: LW];
    assign tlen = i_tx_len[p*LW +: LW];
    assign over = rlen > switch_mac_pkg::TRUNC_LEN;
    assign bin_hi = i_long_stats ? switch_mac_pkg::LONG_MAX_LEN :
                    switch_mac_pkg::STD_MAX_LEN;
    assign cut = i_cut_through[p] && !i_dest_busy[p] &&
                 !(p == 0 && posttag_on);
    assign err = i_rx_crc_err[p] || i_rx_align_err[p] || over;
    assign fd = i_full_duplex[p];
    assign crs = tx_q.crs2 && !fd;
    assign col = tx_q.col2 && !fd;
    assign pace_en = i_port_ctrl[p*8 + switch_mac_pkg::TX_PACING_ENABLE_BIT];
    assign byte_cyc = i_speed100[p] ? CW'(switch_mac_pkg::BYTE100_CYC) :
                      CW'(switch_mac_pkg::BYTE10_CYC);
    assign gap_cyc = i_speed100[p] ? CW'(switch_mac_pkg::GAP100_CYC) :
                     CW'(switch_mac_pkg::GAP10_CYC);
    assign pace_cyc = CW'(switch_mac_pkg::PACE_GAPS) * gap_cyc;

    always_comb begin
      rx_d = '0;
      if (i_rx_done[p]) begin
        rx_d.trunc = over;
        if (rlen < switch_mac_pkg::MIN_LEN) begin
          rx_d.drop = 1'b1;
        end else if (!cut && err) begin
          rx_d.drop = 1'b1;
          rx_d.rel = 1'b1;
          rx_d.crc = i_rx_crc_err[p];
          rx_d.align = i_rx_align_err[p];
        end else begin
          rx_d.store = 1'b1;
        end
        rx_d.bin = !i_rx_crc_err[p] && rlen >= switch_mac_pkg::BIN_LO_LEN
                   && rlen <= bin_hi;
        rx_d.jab = i_rx_crc_err[p] &&
                   rlen > switch_mac_pkg::STD_MAX_LEN;
      end
    end

    always_comb begin
      tx_d = tx_q;
      tx_d.done = 1'b0;
      tx_d.retry = 1'b0;
      tx_d.late = 1'b0;
      tx_d.excess = 1'b0;
      tx_d.crs1 = i_port_carrier_sense[p];
      tx_d.crs2 = tx_q.crs1;
      tx_d.col1 = i_port_collision[p];
      tx_d.col2 = tx_q.col1;
      tx_d.lfsr = {tx_q.lfsr[8:0], tx_q.lfsr[9] ^ tx_q.lfsr[6]};
      bo_mask = 10'(({10'h000, 1'b1} << ((tx_q.tries > 5'(
                switch_mac_pkg::BACKOFF_LIMIT)) ? 5'(switch_mac_pkg::
                BACKOFF_LIMIT) : tx_q.tries)) - 11'd1);
      if (tx_q.pace != '0) begin
        tx_d.pace = tx_q.pace - CW'(1);
      end
      unique case (tx_q.st)
        switch_mac_pkg::TX_IDLE: begin
          if (i_tx_req[p]) begin
            tx_d.cnt = '0;
            tx_d.bytes = '0;
            if (pace_en && tx_q.pace != '0) begin
              tx_d.st = switch_mac_pkg::TX_PACE;
            end else if (crs) begin
              tx_d.pace = pace_cyc;
            end else begin
              tx_d.st = switch_mac_pkg::TX_SEND;
            end
          end
        end
        switch_mac_pkg::TX_PACE: begin
          tx_d.cnt = tx_q.cnt + CW'(1);
          if (tx_q.cnt >= pace_cyc - CW'(1)) begin
            tx_d.st = switch_mac_pkg::TX_IDLE;
          end
        end
        switch_mac_pkg::TX_SEND: begin
          tx_d.cnt = tx_q.cnt + CW'(1);
          if (col && tx_q.bytes >= switch_mac_pkg::LATE_BYTES) begin
            tx_d.late = 1'b1;
            tx_d.tries = '0;
            tx_d.coll = 1'b1;
            tx_d.cnt = '0;
            tx_d.st = switch_mac_pkg::TX_GAP;
          end else if (col) begin
            tx_d.st = switch_mac_pkg::TX_JAM;
            tx_d.tries = tx_q.tries + 5'd1;
            tx_d.pace = pace_cyc;
            tx_d.cnt = '0;
            tx_d.bytes = '0;
          end else if (tx_q.cnt == byte_cyc - CW'(1)) begin
            tx_d.cnt = '0;
            tx_d.bytes = tx_q.bytes + LW'(1);
            if (tx_q.bytes + LW'(1) >= tlen) begin
              tx_d.done = 1'b1;
              tx_d.tries = '0;
              tx_d.coll = 1'b0;
              tx_d.st = switch_mac_pkg::TX_GAP;
            end
          end
        end
        switch_mac_pkg::TX_JAM: begin
          tx_d.cnt = tx_q.cnt + CW'(1);
          if (tx_q.cnt == byte_cyc - CW'(1)) begin
            tx_d.cnt = '0;
            tx_d.bytes = tx_q.bytes + LW'(1);
            if (tx_q.bytes + LW'(1) == switch_mac_pkg::JAM_BYTES) begin
              tx_d.coll = 1'b1;
              if (tx_q.tries == switch_mac_pkg::MAX_TRIES) begin
                tx_d.excess = 1'b1;
                tx_d.tries = '0;
                tx_d.st = switch_mac_pkg::TX_GAP;
              end else begin
                tx_d.retry = 1'b1;
                tx_d.cnt = CW'(tx_q.lfsr & bo_mask) *
                           CW'(switch_mac_pkg::SLOT_BYTES) * byte_cyc;
                tx_d.st = switch_mac_pkg::TX_BACKOFF;
              end
            end
          end
        end
        switch_mac_pkg::TX_BACKOFF: begin
          tx_d.cnt = tx_q.cnt - CW'(1);
          if (tx_q.cnt == '0) begin
            tx_d.st = switch_mac_pkg::TX_GAP;
          end
        end
        switch_mac_pkg::TX_GAP: begin
          tx_d.cnt = tx_q.cnt + CW'(1);
          if (tx_q.coll && crs) begin
            tx_d.cnt = '0;
          end else if (tx_q.cnt >= gap_cyc - CW'(1)) begin
            tx_d.cnt = '0;
            tx_d.st = switch_mac_pkg::TX_IDLE;
          end
        end
        default: tx_d.st = switch_mac_pkg::TX_IDLE;
      endcase
      tx_d.txen = tx_d.st == switch_mac_pkg::TX_SEND ||
                  tx_d.st == switch_mac_pkg::TX_JAM;
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        rx_q <= '0;
        tx_q <= TX_RST;
      end else begin
        rx_q <= rx_d;
        tx_q <= tx_d;
      end
    end

    assign o_rx_store[p] = rx_q.store;
    assign o_rx_drop[p] = rx_q.drop;
    assign o_rx_truncate[p] = rx_q.trunc;
    assign o_stat_long_bin[p] = rx_q.bin;
    assign o_stat_jabber[p] = rx_q.jab;
    assign o_stat_crc[p] = rx_q.crc;
    assign o_stat_align[p] = rx_q.align;
    assign o_buf_release[p] = rx_q.rel;
    assign txen_q[p] = tx_q.txen;
    assign o_port_tx_enable[p] = tx_q.txen;
    assign o_tx_release[p] = tx_q.done;
    assign o_tx_retry[p] = tx_q.retry;
    assign o_tx_late[p] = tx_q.late;
    assign o_tx_excess[p] = tx_q.excess;

    short_drop_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      i_rx_done[p] && rlen < switch_mac_pkg::MIN_LEN
      |=> o_rx_drop[p] && !o_rx_store[p])
      else $error("short frame reached memory");
    over_sf_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      i_rx_done[p] && over && !i_cut_through[p]
      |=> o_rx_drop[p] && o_rx_truncate[p] && o_buf_release[p])
      else $error("long frame kept in store and forward");
    long_bin_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      i_rx_done[p] && !i_rx_crc_err[p] && rlen == switch_mac_pkg::LONG_MAX_LEN
      |=> o_stat_long_bin[p] == $past(i_long_stats))
      else $error("long bin option ignored");
    early_jam_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      tx_q.st == switch_mac_pkg::TX_SEND && col &&
      tx_q.bytes < switch_mac_pkg::LATE_BYTES
      |=> tx_q.st == switch_mac_pkg::TX_JAM && o_port_tx_enable[p])
      else $error("early collision not jammed");
    late_coll_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      tx_q.st == switch_mac_pkg::TX_SEND && col &&
      tx_q.bytes >= switch_mac_pkg::LATE_BYTES
      |=> o_tx_late[p] && !o_port_tx_enable[p] ##1 !o_tx_retry[p])
      else $error("late collision retried");
    full_duplex_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      fd && tx_q.st == switch_mac_pkg::TX_SEND
      |=> tx_q.st != switch_mac_pkg::TX_JAM)
      else $error("full duplex port jammed");
    release_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      o_tx_release[p] |-> $past(tx_q.st) == switch_mac_pkg::TX_SEND &&
      !$past(col))
      else $error("data released without clean send");
    pace_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      tx_q.st == switch_mac_pkg::TX_IDLE && i_tx_req[p] && pace_en &&
      tx_q.pace != '0 |=> tx_q.st == switch_mac_pkg::TX_PACE)
      else $error("pacing wait skipped");
  end
endmodule

// File: switch_mac_pkg.sv
// constants, state types and timing for the switch port mac block
// assumes a 40 MHz core clock and a separate uplink link clock
package switch_mac_pkg;
  // ==========================================================
  // structure
  localparam int NPORTS = 10;
  localparam int LEN_W = 11;
  localparam int CNT_W = 22;
  // ==========================================================
  // registers
  localparam logic [15:0] RAM_SIZE_CONFIG_ADDR = 16'h00D2;
  localparam logic [7:0] RAM_SIZE_CONFIG_RST = 8'h00;
  localparam int POSTTAG_ENABLE_BIT = 4;
  localparam int TX_PACING_ENABLE_BIT = 1;
  // ==========================================================
  // frame lengths in bytes, retry and backoff limits
  localparam logic [LEN_W-1:0] MIN_LEN = 11'd64;
  localparam logic [LEN_W-1:0] BIN_LO_LEN = 11'd1024;
  localparam logic [LEN_W-1:0] STD_MAX_LEN = 11'd1518;
  localparam logic [LEN_W-1:0] LONG_MAX_LEN = 11'd1531;
  localparam logic [LEN_W-1:0] TRUNC_LEN = 11'd1535;
  localparam logic [LEN_W-1:0] LATE_BYTES = 11'd64;
  localparam logic [LEN_W-1:0] JAM_BYTES = 11'd4;
  localparam int SLOT_BYTES = 64;
  localparam logic [4:0] MAX_TRIES = 5'd16;
  localparam int BACKOFF_LIMIT = 10;
  // ==========================================================
  // timing
  localparam int CLK_NS = 25;
  localparam int GAP10_NS = 9600;
  localparam int GAP100_NS = 960;
  localparam int BYTE10_NS = 800;
  localparam int BYTE100_NS = 80;
  localparam int PACE_GAPS = 4;
  localparam int GAP10_CYC = (GAP10_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP100_CYC = (GAP100_NS + CLK_NS - 1) / CLK_NS;
  localparam int BYTE10_CYC = BYTE10_NS / CLK_NS;
  localparam int BYTE100_CYC = BYTE100_NS / CLK_NS;
  // ==========================================================
  // transmit states
  typedef enum logic [2:0] {
    TX_IDLE, TX_GAP, TX_PACE, TX_SEND, TX_JAM, TX_BACKOFF
  } tx_state_e;
endpackage

// File: uplink_engine_model.sv
// routing engine model driving the uplink receive side
// assumes the free running uplink clock made by the bench
`timescale 1ns/10ps
module uplink_engine_model (
  input wire logic i_uplink_clk,
  output logic o_uplink_rx_valid,
  output logic [3:0] o_uplink_rx_nibble
);
  initial begin
    o_uplink_rx_valid = 1'b0;
    o_uplink_rx_nibble = 4'h5;
  end
  // ==========================================================
  // one frame: pretag, three posttag nibbles, data
  task automatic send(input logic [15:0] tags);
    @(posedge i_uplink_clk);
    o_uplink_rx_nibble <= tags[15:12];
    for (int k = 0; k < 23; k++) begin
      @(posedge i_uplink_clk);
      o_uplink_rx_valid <= 1'b1;
      o_uplink_rx_nibble <= k < 3 ? tags[11-4*k -: 4] : 4'($urandom);
    end
    @(posedge i_uplink_clk);
    o_uplink_rx_valid <= 1'b0;
    o_uplink_rx_nibble <= ~o_uplink_rx_nibble;
  endtask
endmodule

// File: switch_port_mac_uplink_tagging_tb.sv
// self-checking bench for the switch port mac block
// assumes the engine model on the uplink receive pins
`timescale 1ns/10ps
module switch_port_mac_uplink_tagging_tb;
  logic clk = 1'b0, rst = 1'b1, uclk = 1'b0, cfg_wr = 1'b0, lng = 1'b0;
  logic [15:0] cfg_addr = 16'h0000;
  logic [7:0] cfg_wdata = 8'h00, ram_cfg;
  logic [79:0] port_ctrl = 80'h0;
  logic [9:0] fdx = 10'h3E7, spd = 10'h3FF, cut = 10'h0, rx_done = 10'h0;
  logic [9:0] crc = 10'h0, algn = 10'h0, busy = 10'h0, tx_req = 10'h0;
  logic [9:0] crs = 10'h0, col = 10'h0, txen, rel, rty, late, exc, udest;
  logic [9:0] st, dr, tr, lb, jb, sc, sa, br;
  logic [109:0] rx_len = 110'h0, tx_len = 110'h0;
  logic [3:0] src = 4'h3, utxd = 4'h0, utxnib, urxn, fwd, pnib;
  logic lsd, utxen, urxv, ufr, uuni, umul, udis, pen = 1'b0;
  logic [15:0] exp_q[$];
  int miscompares = 0, checks_done = 0, gap = 0, last_gap = 0;
  always #12.5 clk = ~clk;
  always #15 uclk = ~uclk;
  switch_port_mac switch_port_mac_i (.i_sys_clk(clk), .i_sys_rst(rst),
    .i_uplink_clk(uclk), .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_addr),
    .i_cfg_wdata(cfg_wdata), .o_ram_size_config(ram_cfg),
    .o_local_switch_disable(lsd), .i_port_ctrl(port_ctrl),
    .i_full_duplex(fdx), .i_speed100(spd), .i_cut_through(cut),
    .i_long_stats(lng), .i_rx_done(rx_done), .i_rx_len(rx_len),
    .i_rx_crc_err(crc), .i_rx_align_err(algn), .i_dest_busy(busy),
    .o_rx_store(st), .o_rx_drop(dr), .o_rx_truncate(tr),
    .o_stat_long_bin(lb), .o_stat_jabber(jb), .o_stat_crc(sc),
    .o_stat_align(sa), .o_buf_release(br), .i_tx_req(tx_req),
    .i_tx_len(tx_len), .i_port_carrier_sense(crs),
    .i_port_collision(col), .o_port_tx_enable(txen), .o_tx_release(rel),
    .o_tx_retry(rty), .o_tx_late(late), .o_tx_excess(exc),
    .i_uplink_src_port(src), .i_uplink_tx_data(utxd),
    .o_uplink_tx_enable(utxen), .o_uplink_tx_nibble(utxnib),
    .i_uplink_rx_valid(urxv), .i_uplink_rx_nibble(urxn),
    .o_fwd_pointer_tag(fwd), .o_uplink_dest(udest), .o_uplink_frame(ufr),
    .o_uplink_unicast(uuni), .o_uplink_multicast(umul),
    .o_uplink_discard(udis));
  uplink_engine_model uplink_engine_model_i (.i_uplink_clk(uclk),
    .o_uplink_rx_valid(urxv), .o_uplink_rx_nibble(urxn));
  // ==========================================================
  // compare, report, close
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic take(input logic [15:0] code);
    if (exp_q.size() == 0) check_val(code, 16'h0000);
    else check_val(code, exp_q.pop_front());
  endtask
  // ==========================================================
  // result watchers
  always @(posedge clk) begin
    for (int p = 0; p < 10; p++) begin
      if ({st[p], dr[p], tr[p], lb[p], jb[p], sc[p], sa[p], br[p]} != 0)
        take({4'h1, 4'(p), st[p], dr[p], tr[p], lb[p], jb[p], sc[p], sa[p], br[p]});
      if ({rel[p], rty[p], late[p], exc[p]} != 0)
        take({4'h2, 4'(p), 4'h0, rel[p], rty[p], late[p], exc[p]});
    end
    if (ufr) take({13'h1800, uuni, umul, udis});
    gap <= txen[3] ? 0 : gap + 1;
    if (txen[3] && gap != 0) last_gap <= gap;
  end
  always @(posedge uclk) begin
    utxd <= 4'($urandom);
    if (utxen && !pen) check_val(16'(pnib), 16'(src));
    pen <= utxen;
    pnib <= utxnib;
  end
  // ==========================================================
  // drivers
  task automatic cfg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic rx(input int p, len, input bit c, ct, b);
    logic [7:0] e;
    @(posedge clk);
    e = {1'b0, 1'b0, 1'(len > 1535), 1'(!c && len >= 1024 && len <= (lng ? 1531 : 1518)),
      1'(c && len > 1518), 3'h0};
    if (len < 64) e = 8'h40;
    else if (!(ct && !b) && (c || len > 1535)) e = e | 8'h41 | (c ? 8'h04 : 8'h00);
    else e[7] = 1'b1;
    exp_q.push_back({4'h1, 4'(p), e});
    rx_done[p] <= 1'b1;
    rx_len[p*11 +: 11] <= 11'(len);
    crc[p] <= c;
    cut[p] <= ct;
    busy[p] <= b;
    @(posedge clk);
    rx_done[p] <= 1'b0;
  endtask
  task automatic tx(input int p, len, col_at, dfr, input logic [3:0] ev);
    int n;
    n = 0;
    @(posedge clk);
    tx_req[p] <= 1'b1;
    tx_len[p*11 +: 11] <= 11'(len);
    crs[p] <= dfr != 0;
    if (ev == 4'h0) exp_q.push_back({4'h2, 4'(p), 8'h04});
    exp_q.push_back({4'h2, 4'(p), 4'h0, ev | 4'(ev == 0) << 3});
    while (!(rel[p] === 1'b1 || late[p] === 1'b1) && n < 3000) begin
      @(posedge clk);
      n++;
      col[p] <= n >= col_at && n < col_at + 4;
      crs[p] <= n < dfr;
    end
    if (n >= 3000) begin
      miscompares++;
      conclude();
    end
    tx_req[p] <= 1'b0;
    $display("tx test ended on port %0d", p);
  endtask
  task automatic up_rx(input logic [11:0] t, input logic [2:0] ev, input logic [9:0] d);
    logic [3:0] pt;
    int n;
    pt = 4'($urandom);
    n = 0;
    exp_q.push_back({13'h1800, ev});
    uplink_engine_model_i.send({pt, t});
    while (exp_q.size() != 0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      miscompares++;
      conclude();
    end
    check_val(16'(fwd), 16'(pt));
    if (!ev[0]) check_val(16'(udest), 16'(d));
    $display("uplink rx test ended");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int p;
    void'($urandom(54209));
    p = 1 + $urandom % 9;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cfg(16'h00D2, 8'h10);
    cfg(16'h00D3, 8'hFF);
    @(posedge clk);
    check_val(16'(ram_cfg), 16'h0010);
    check_val(16'(lsd), 16'h0001);
    $display("config test ended");
    rx(p, 40, 0, 0, 0);
    rx(p, 63, 0, 1, 0);
    rx(p, 64 + $urandom % 900, 0, 0, 0);
    rx(p, 1600, 0, 1, 0);
    rx(p, 1600, 0, 0, 0);
    rx(p, 100, 1, 0, 0);
    rx(p, 200, 1, 1, 1);
    rx(p, 1525, 1, 0, 0);
    rx(p, 1525, 0, 0, 0);
    lng <= 1'b1;
    rx(p, 1531, 0, 0, 0);
    rx(p, 1532, 0, 0, 0);
    $display("rx filter test ended");
    port_ctrl[25] <= 1'b1;
    tx(3, 2, 9999, 0, 4'h8);
    tx(3, 2, 9999, 0, 4'h8);
    check_val(16'(last_gap >= 39 && last_gap < 47), 16'h0001);
    tx(3, 2, 9999, 60, 4'h8);
    check_val(16'(last_gap >= 195 && last_gap < 205), 16'h0001);
    tx(4, 100, 10, 0, 4'h0);
    tx(4, 100, 250, 0, 4'h2);
    tx(5, 100, 10, 0, 4'h8);
    src <= 4'(1 + $urandom % 9);
    tx(0, 4, 9999, 0, 4'h8);
    up_rx(12'h040, 3'h4, 10'h080);
    up_rx(12'hA91, 3'h2, 10'h334);
    up_rx(12'h00E, 3'h1, 10'h000);
    repeat (20) @(posedge clk);
    check_val(16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule
